// ---- inc/hwt_defs.vh ----
// hibernation wake timer: register offsets, fields, reset values, timing counts
// assumes hclk at 100 MHz and a 32.768 kHz always-on clock arriving as a plain input
`ifndef HWT_DEFS_VH
`define HWT_DEFS_VH
`define HWT_OFF_PRELOAD 8'h00
`define HWT_OFF_CONTROL 8'h04
`define HWT_OFF_COUNT 8'h08
`define HWT_OFF_STATUS 8'h0c
`define HWT_OFF_MASK 8'h10
`define HWT_CTRL_RES_BIT 0
`define HWT_RST_PRELOAD 16'h0000
`define HWT_RST_CONTROL 16'h0000
`define HWT_RST_COUNT 16'h0000
`define HWT_RST_MASK 1'b0
// one fine step is one 32.768 kHz tick (30.5 us); a coarse step (0.125 s) is 4096 ticks
`define HWT_FINE_TICKS 13'h0001
`define HWT_COARSE_TICKS 13'h1000
`define HWT_CLKREQ_CYCLES 4'h3
`endif

// ---- core/hwt_timer.v ----
// hibernation wake timer: 16-bit down counter with ahb-lite register slave
// assumes a single ahb-lite master; the 32 kHz clock is a pin sampled on hclk
`timescale 1ns/1ps
`include "hwt_defs.vh"

// Function
// - counter is a 16-bit binary down counter
// - step is either 30.5 us or 0.125 s per count
// - writing a non-zero start value loads the counter and starts counting
// - reaching zero raises the wake interrupt event
// - counting steps on the 32 kHz clock through a prescaler
// - reset returns every register and the counter to defaults
// - interrupt output only when enabled and counted to zero
// - counting steps on 32 kHz edges sampled on hclk, so it needs the main oscillator too
// - sleep-enable inputs are ignored
// - clock request asserted only around register accesses
// - preload at 00h, control at 04h, count at 08h
// - writing zero to preload disables the counter
// - resolution bit: 1 selects 0.125 s, 0 selects 30.5 us
// - count register reads the live counter
module hwt_timer (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire clk32k_in,
  input wire sleep_en,
  output reg clk_req,
  output reg wake_timer_irq
);

  ////////////////////////////////////////////////////////////////////////
  // register decode and state
  reg [15:0] start_value_q;
  reg [15:0] start_value_d;
  reg res_q;
  reg res_d;
  reg [15:0] count_q;
  reg [15:0] count_d;
  reg enabled_q;
  reg enabled_d;
  reg [12:0] presc_q;
  reg [12:0] presc_d;
  reg status_q;
  reg status_d;
  reg mask_q;
  reg mask_d;
  reg wr_pend_q;
  reg wr_pend_d;
  reg [7:0] wr_addr_q;
  reg [7:0] wr_addr_d;
  reg [3:0] req_cnt_q;
  reg [3:0] req_cnt_d;
  reg [31:0] hrdata_d;
  reg irq_d;
  reg clk_req_d;
  reg s1_q;
  reg s2_q;
  reg s3_q;
  wire tick32;
  wire addr_ph;
  wire rd_ph;
  wire wr_pre;
  wire wr_ctl;
  wire wr_sts;
  wire wr_msk;
  wire clr_sts;
  wire [12:0] step_last;
  wire step;
  wire zero_evt;
  wire unused_ok;

  function is_off;
    input [7:0] a;
    input [7:0] off;
    begin
      is_off = (a == off);
    end
  endfunction

  // read mux; fed with next-state values so a read right behind a write sees the new word
  function [31:0] read_word;
    input [7:0] a;
    input [15:0] pre;
    input ctl;
    input [15:0] cnt;
    input sts;
    input msk;
    begin
      case (a)
        `HWT_OFF_PRELOAD: read_word = {16'h0000, pre};
        `HWT_OFF_CONTROL: read_word = {31'h0000_0000, ctl};
        `HWT_OFF_COUNT: read_word = {16'h0000, cnt};
        `HWT_OFF_STATUS: read_word = {31'h0000_0000, sts};
        `HWT_OFF_MASK: read_word = {31'h0000_0000, msk};
        default: read_word = 32'h0000_0000;
      endcase
    end
  endfunction

  // sleep_en and the upper address/size bits have no effect on the timer
  assign unused_ok = sleep_en & hsize[0];
  assign addr_ph = hsel & hready & htrans[1];
  assign rd_ph = addr_ph & ~hwrite;
  assign wr_pre = wr_pend_q & is_off(wr_addr_q, `HWT_OFF_PRELOAD);
  assign wr_ctl = wr_pend_q & is_off(wr_addr_q, `HWT_OFF_CONTROL);
  assign wr_sts = wr_pend_q & is_off(wr_addr_q, `HWT_OFF_STATUS);
  assign wr_msk = wr_pend_q & is_off(wr_addr_q, `HWT_OFF_MASK);
  assign clr_sts = wr_sts & hwdata[0];

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, always okay
  always @* begin
    wr_pend_d = addr_ph & hwrite;
    wr_addr_d = haddr[7:0];
    hrdata_d = 32'h0000_0000;
    if (rd_ph) begin
      // registered in the address phase so the word stands through the data phase
      hrdata_d = read_word(haddr[7:0], start_value_d, res_d, count_d, status_d, mask_d);
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
    end
  end

  // bus outputs straight from flops; the slave never stalls and never errs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= hrdata_d;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // 32 kHz pin: two-flop sync, then edge detect on the second and third flops
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= clk32k_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // a tick seen just after reset is harmless: the counter starts disabled
  assign tick32 = s2_q & ~s3_q;

  ////////////////////////////////////////////////////////////////////////
  // prescaler and down counter
  assign step_last = (res_q ? `HWT_COARSE_TICKS : `HWT_FINE_TICKS) - 13'h0001;
  // at or beyond the last tick, so a coarse-to-fine change mid-step cannot strand the prescaler
  assign step = enabled_q & tick32 & (presc_q >= step_last);
  assign zero_evt = step & (count_q == 16'h0001);

  always @* begin
    start_value_d = start_value_q;
    res_d = res_q;
    count_d = count_q;
    enabled_d = enabled_q;
    presc_d = presc_q;
    if (wr_ctl) begin
      res_d = hwdata[`HWT_CTRL_RES_BIT];
    end
    if (wr_pre) begin
      start_value_d = hwdata[15:0];
      count_d = hwdata[15:0];
      presc_d = 13'h0000;
      enabled_d = (hwdata[15:0] != 16'h0000);
    end else if (step) begin
      presc_d = 13'h0000;
      count_d = count_q - 16'h0001;
      if (count_q == 16'h0001) begin
        enabled_d = 1'b0;
      end
    end else if (enabled_q & tick32) begin
      presc_d = presc_q + 13'h0001;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_value_q <= `HWT_RST_PRELOAD;
    end else begin
      start_value_q <= start_value_d;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_q <= 1'b0;
    end else begin
      res_q <= res_d;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= `HWT_RST_COUNT;
    end else begin
      count_q <= count_d;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enabled_q <= 1'b0;
    end else begin
      enabled_q <= enabled_d;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_q <= 13'h0000;
    end else begin
      presc_q <= presc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky status, mask, interrupt
  always @* begin
    status_d = status_q;
    mask_d = mask_q;
    // set wins: a zero event in the same cycle as a write-one-to-clear keeps the bit
    if (zero_evt) begin
      status_d = 1'b1;
    end else if (clr_sts) begin
      status_d = 1'b0;
    end
    if (wr_msk) begin
      mask_d = hwdata[0];
    end
    irq_d = status_d & mask_q;
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= 1'b0;
    end else begin
      status_q <= status_d;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= `HWT_RST_MASK;
    end else begin
      mask_q <= mask_d;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_timer_irq <= 1'b0;
    end else begin
      wake_timer_irq <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock request: held a few cycles after each access so a late write still reaches the core
  always @* begin
    req_cnt_d = req_cnt_q;
    if (addr_ph) begin
      req_cnt_d = `HWT_CLKREQ_CYCLES;
    end else if (req_cnt_q != 4'h0) begin
      req_cnt_d = req_cnt_q - 4'h1;
    end
    // sleep_en folds in as a constant zero: a sleep request never touches the timer
    clk_req_d = addr_ph | (req_cnt_q > 4'h1) | (unused_ok & 1'b0);
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_cnt_q <= 4'h0;
    end else begin
      req_cnt_q <= req_cnt_d;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_req <= 1'b0;
    end else begin
      clk_req <= clk_req_d;
    end
  end

endmodule

// ---- verif/hwt_timer_asserts.sv ----
// port checker for the wake timer
// assumes one hclk domain; bound to hwt_timer
`timescale 1ns/1ps
module hwt_chk (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire clk_req,
  input wire wake_timer_irq
);
  wire acc = hsel && hready && htrans[1];
  wire wr = acc && hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_RDY: assert property (hreadyout) else $error("slave not ready");
  AST_OKAY: assert property (!hresp) else $error("error response");
  AST_RDIDLE: assert property (!acc |=> hrdata == 32'h0) else $error("read data off phase");
  AST_UPPER: assert property (acc && !hwrite |=> hrdata[31:16] == 16'h0) else $error("upper bits set");
  AST_REQON: assert property (acc |-> ##[1:2] clk_req) else $error("no clock request");
  AST_REQOFF: assert property (!acc [*6] |-> !clk_req) else $error("stray clock request");
  // status is sticky, so only a write may drop the interrupt
  AST_HOLD: assert property (!wr [*3] ##0 wake_timer_irq |=> wake_timer_irq) else $error("irq dropped");
  AST_RST: assert property ($rose(hresetn) |-> !wake_timer_irq && !clk_req) else $error("reset state");
endmodule
bind hwt_timer hwt_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .clk_req(clk_req),
  .wake_timer_irq(wake_timer_irq));

// ---- verif/hwt_timer_tb.sv ----
// self-checking bench for the wake timer
// assumes the bench makes slow 32 kHz pulses itself
`timescale 1ns/1ps
module hwt_timer_tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, clk32k_in = 0, sleep_en = 0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, clk_req, irq;
  int error_cnt = 0, total_checks = 0, cyc = 0, seed = 28, mcnt;
  always #5 hclk = ~hclk;
  hwt_timer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .clk32k_in(clk32k_in), .sleep_en(sleep_en),
    .clk_req(clk_req), .wake_timer_irq(irq));
  ////////////////////////////////////////////////////////////
  task stop_test;
    $display("errors %0d checks %0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task rchk(input string s, input logic [7:0] a, input logic [31:0] e);
    bus(0, a, 32'h0);
    chk(s, e, rd);
  endtask
  // one pulse per tick, slow enough for the two-flop sync
  task tick(input int k);
    repeat (k) begin
      repeat (4) @(posedge hclk); clk32k_in <= 1;
      repeat (4) @(posedge hclk); clk32k_in <= 0;
    end
    repeat (6) @(posedge hclk);
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin error_cnt++; stop_test; end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    for (int i = 0; i < 6; i++) rchk("reset", 8'(i * 4), 32'h0);
    bus(1, 8'h10, 32'h1);
    sleep_en <= 1;
    mcnt = 4 + {$random(seed)} % 8;
    bus(1, 8'h00, 32'(mcnt));
    rchk("preload", 8'h00, 32'(mcnt));
    chk("clk_req", 32'h1, {31'h0, clk_req});
    rchk("count", 8'h08, 32'(mcnt));
    tick(3);
    chk("clk_req idle", 32'h0, {31'h0, clk_req});
    mcnt -= 3;
    rchk("count", 8'h08, 32'(mcnt));
    chk("irq", 32'h0, {31'h0, irq});
    tick(mcnt + 2);
    rchk("count", 8'h08, 32'h0);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1, 8'h0c, 32'h1);
    bus(1, 8'h08, 32'h1234);
    rchk("ro count", 8'h08, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    bus(1, 8'h00, 32'h5);
    bus(1, 8'h00, 32'h0);
    tick(6);
    rchk("status", 8'h0c, 32'h0);
    bus(1, 8'h10, 32'h0);
    bus(1, 8'h00, 32'h1);
    tick(2);
    rchk("status", 8'h0c, 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
    bus(1, 8'h10, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1, 8'h04, 32'h1);
    rchk("control", 8'h04, 32'h1);
    bus(1, 8'h00, 32'h2);
    tick(4095);
    rchk("coarse", 8'h08, 32'h2);
    tick(1);
    rchk("coarse step", 8'h08, 32'h1);
    hresetn <= 0;
    @(posedge hclk);
    hresetn <= 1;
    rchk("rst ctl", 8'h04, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    stop_test;
  end
endmodule
